// >>> verilog/synth_core.v
/*
 * Pulse-swallow synthesiser divider with two or three moduli, reference
 * divide-by-four and type II phase/frequency comparator.
 * Assumes vco_in and ref_osc_in are synchronous levels slower than clk_in / 2.
 */
`timescale 1ns/100ps
`default_nettype none
`include "synth_core_defines.vh"

module synth_core #(
    parameter CW = 10,
    parameter PW = 7,
    parameter [PW-1:0] BASE_MOD = `MOD_BASE,
    parameter [PW-1:0] STEP_Q = `MOD_STEP
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire vco_in,
    input wire ref_osc_in,
    input wire three_mod_in,
    input wire ext_ctrl_sel_in,
    input wire mod_ctrl_in,
    input wire [CW-1:0] swallow_count_in,
    input wire [CW-1:0] mid_count_in,
    input wire [CW-1:0] main_count_in,
    output reg prescale_pulse_out,
    output reg mod_ctrl_out,
    output reg div_pulse_out,
    output reg fb_out,
    output reg ref_div_out,
    output reg pump_up_n_out,
    output reg pump_down_out
);

    localparam [2:0] ST_HIGH = 3'b001;
    localparam [2:0] ST_MID = 3'b010;
    localparam [2:0] ST_LOW = 3'b100;
    localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input edges

    reg rst_meta_reg;
    reg rst_sync_reg;
    reg vco_prev_reg;
    reg ref_prev_reg;
    reg start_reg;
    wire rst_n;
    wire vco_rise;
    wire ref_rise;

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            vco_prev_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
            start_reg <= 1'b1;
        end else begin
            vco_prev_reg <= vco_in;
            ref_prev_reg <= ref_osc_in;
            start_reg <= 1'b0;
        end
    end
    assign vco_rise = vco_in & ~vco_prev_reg;
    assign ref_rise = ref_osc_in & ~ref_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler modulus selection

    reg [2:0] stage_reg;
    reg [2:0] stage_next;
    reg [PW-1:0] modulus;
    wire pre_wrap;

    always @* begin
        modulus = BASE_MOD;
        if (ext_ctrl_sel_in && !three_mod_in) begin
            modulus = mod_ctrl_in ? BASE_MOD + STEP_Q : BASE_MOD;
        end else if (three_mod_in) begin
            case (stage_reg)
                ST_HIGH: modulus = `MOD3_HIGH;
                ST_MID: modulus = `MOD3_MID;
                ST_LOW: modulus = `MOD3_LOW;
                default: modulus = `MOD3_LOW;
            endcase
        end else begin
            // Pair differs by STEP_Q; one gives every integer ratio
            modulus = (stage_reg == ST_HIGH) ? BASE_MOD + STEP_Q : BASE_MOD;
        end
    end

    modulus_counter #(
        .W(PW)
    ) prescaler_u (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .restart_in(start_reg),
        .step_in(vco_rise),
        .modulus_in(modulus),
        .wrap_out(pre_wrap)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Swallow, middle and main counters

    reg [CW-1:0] sw_reg;
    reg [CW-1:0] sw_next;
    reg [CW-1:0] mid_reg;
    reg [CW-1:0] mid_next;
    reg [CW-1:0] main_reg;
    reg [CW-1:0] main_next;
    reg [CW-1:0] sw_lim_reg;
    reg [CW-1:0] sw_lim_next;
    reg [CW-1:0] mid_lim_reg;
    reg [CW-1:0] mid_lim_next;
    reg [CW-1:0] main_lim_reg;
    reg [CW-1:0] main_lim_next;
    reg cycle_end;
    wire [CW-1:0] sw_inc;
    wire [CW-1:0] mid_inc;
    wire [CW-1:0] main_inc;

    assign sw_inc = sw_reg + ONE;
    assign mid_inc = mid_reg + ONE;
    assign main_inc = main_reg + ONE;

    // Stage that opens a cycle; zero counts skip their stage
    function [2:0] first_stage;
        input [CW-1:0] a1;
        input [CW-1:0] a2;
        input three;
        begin
            if (a1 != {CW{1'b0}}) begin
                first_stage = ST_HIGH;
            end else if (three && a2 != {CW{1'b0}}) begin
                first_stage = ST_MID;
            end else begin
                first_stage = ST_LOW;
            end
        end
    endfunction

    always @* begin
        stage_next = stage_reg;
        sw_next = sw_reg;
        mid_next = mid_reg;
        main_next = main_reg;
        sw_lim_next = sw_lim_reg;
        mid_lim_next = mid_lim_reg;
        main_lim_next = main_lim_reg;
        cycle_end = 1'b0;
        if (start_reg || (pre_wrap && main_inc == main_lim_reg)) begin
            cycle_end = pre_wrap & ~start_reg;
            sw_next = {CW{1'b0}};
            mid_next = {CW{1'b0}};
            main_next = {CW{1'b0}};
            sw_lim_next = swallow_count_in;
            mid_lim_next = mid_count_in;
            main_lim_next = main_count_in;
            stage_next = first_stage(swallow_count_in, mid_count_in, three_mod_in);
        end else if (pre_wrap) begin
            // Ratio is (BASE+Q)*A + BASE*(M-A) = BASE*M + Q*A; needs M >= A
            main_next = main_inc;
            case (stage_reg)
                ST_HIGH: begin
                    sw_next = sw_inc;
                    if (sw_inc == sw_lim_reg) begin
                        if (three_mod_in && mid_lim_reg != {CW{1'b0}}) begin
                            stage_next = ST_MID;
                        end else begin
                            stage_next = ST_LOW;
                        end
                    end
                end
                ST_MID: begin
                    mid_next = mid_inc;
                    if (mid_inc == mid_lim_reg) begin
                        stage_next = ST_LOW;
                    end
                end
                ST_LOW: stage_next = ST_LOW;
                default: stage_next = ST_LOW;
            endcase
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= ST_HIGH;
            sw_reg <= {CW{1'b0}};
            mid_reg <= {CW{1'b0}};
            main_reg <= {CW{1'b0}};
            sw_lim_reg <= {CW{1'b0}};
            mid_lim_reg <= {CW{1'b0}};
            main_lim_reg <= {CW{1'b0}};
            prescale_pulse_out <= 1'b0;
            mod_ctrl_out <= 1'b1;
            div_pulse_out <= 1'b0;
            fb_out <= 1'b1;
        end else begin
            stage_reg <= stage_next;
            sw_reg <= sw_next;
            mid_reg <= mid_next;
            main_reg <= main_next;
            sw_lim_reg <= sw_lim_next;
            mid_lim_reg <= mid_lim_next;
            main_lim_reg <= main_lim_next;
            prescale_pulse_out <= pre_wrap;
            mod_ctrl_out <= (stage_next == ST_HIGH);
            div_pulse_out <= cycle_end;
            // Feedback falls at cycle end, rises at the next wrap; a main count of one keeps it low
            if (cycle_end) begin
                fb_out <= 1'b0;
            end else if (pre_wrap) begin
                fb_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference divide-by-four

    wire ref_half_wrap;

    modulus_counter #(
        .W(PW)
    ) ref_div_u (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .restart_in(start_reg),
        .step_in(ref_rise),
        .modulus_in(`REF_HALF_MOD),
        .wrap_out(ref_half_wrap)
    );

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ref_div_out <= 1'b1;
        end else if (ref_half_wrap) begin
            // Toggling every second edge gives a square wave at a quarter rate
            ref_div_out <= ~ref_div_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase/frequency comparator: reference is the first input

    reg ref_cmp_prev_reg;
    reg fb_cmp_prev_reg;
    wire ref_fall;
    wire fb_fall;

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ref_cmp_prev_reg <= 1'b1;
            fb_cmp_prev_reg <= 1'b1;
        end else begin
            ref_cmp_prev_reg <= ref_div_out;
            fb_cmp_prev_reg <= fb_out;
        end
    end
    assign ref_fall = ~ref_div_out & ref_cmp_prev_reg;
    assign fb_fall = ~fb_out & fb_cmp_prev_reg;

    // Coincident edges leave both outputs unchanged, so lock gives no residual pulse
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pump_up_n_out <= 1'b1;
            pump_down_out <= 1'b0;
        end else if (ref_fall && !fb_fall) begin
            if (pump_down_out) begin
                pump_down_out <= 1'b0;
            end else begin
                pump_up_n_out <= 1'b0;
            end
        end else if (fb_fall && !ref_fall) begin
            if (!pump_up_n_out) begin
                pump_up_n_out <= 1'b1;
            end else begin
                pump_down_out <= 1'b1;
            end
        end
        // A repeated edge on the active side rewrites the same level, so the output holds
    end

endmodule // synth_core

`default_nettype wire

// >>> verilog/synth_core_defines.vh
/*
 * Constants for the synthesiser divider and phase comparator core.
 * Assumes inclusion by bare name from the design files; no process here.
 */
// Behaviour
// - Prescaler uses larger modulus until swallow counter reaches A, then base modulus.
// - Main counter at M reloads both counters, emits one pulse, restarts cycle.
// - Overall ratio equals base modulus times M plus A.
// - Three-modulus variant divides 110 to A1, 101 to A2, 100 to N.
// - Three-modulus ratio is A2+10*A1+100*N; N at least A1+A2.
// - Two-modulus divider divides by 16 with control high, 15 with low.
// - Reference oscillator only leaves the block divided by four.
// - Comparator reacts only to falling edges of both inputs.
// - Reference leading: pump-up low between edges, pump-down stays low.
// - Reference lagging: pump-down high between edges, pump-up stays high.
// - Two edges on one input without other: output holds until other edge.
// - Leading input keeps lead until other input sees two edges alone.
// - Unlimited pull-in; zero offset at lock with no residual pulse.
// - Modulus pair may differ by any integer Q; one by default.
`ifndef SYNTH_CORE_DEFINES_VH
`define SYNTH_CORE_DEFINES_VH

`define MOD_BASE 7'h0F
`define MOD_STEP 7'h01
`define MOD3_HIGH 7'h6E
`define MOD3_MID 7'h65
`define MOD3_LOW 7'h64
`define REF_HALF_MOD 7'h02

`endif

// >>> verilog/modulus_counter.v
/*
 * Event counter that wraps after a programmable modulus of step events.
 * Assumes step is a one-cycle pulse and modulus is at least one.
 */
`timescale 1ns/100ps
`default_nettype none

module modulus_counter #(
    parameter W = 7
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire restart_in,
    input wire step_in,
    input wire [W-1:0] modulus_in,
    output wire wrap_out
);

    reg [W-1:0] count_reg;
    reg [W-1:0] count_next;
    wire [W-1:0] last_count;

    // Modulus is sampled at every step so a change made on wrap applies to the next cycle
    assign last_count = modulus_in - {{(W-1){1'b0}}, 1'b1};
    assign wrap_out = step_in & ~restart_in & (count_reg == last_count);

    always @* begin
        count_next = count_reg;
        if (restart_in) begin
            count_next = {W{1'b0}};
        end else if (wrap_out) begin
            count_next = {W{1'b0}};
        end else if (step_in) begin
            count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= {W{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

endmodule // modulus_counter

`default_nettype wire

// >>> dv/osc_model.sv
/* Behavioural VCO and reference oscillator for the synthesiser core.
   Assumes the bench gates each source; levels move at the falling clock edge. */
`timescale 1ns/100ps
`default_nettype none
module osc_model #(
    parameter int VCO_HALF = 1,
    parameter int REF_HALF = 2
) (
    input wire logic clk_in,
    input wire logic vco_run_in,
    input wire logic ref_run_in,
    output logic vco_out = 1'b0,
    output logic ref_out = 1'b0
);
int vc = 0;
int rc = 0;
// A stopped source holds its level, as a real oscillator that is gated off
always @(negedge clk_in) begin
    vc = vco_run_in ? vc + 1 : 0;
    rc = ref_run_in ? rc + 1 : 0;
    if (vc == VCO_HALF) begin
        vco_out <= ~vco_out;
        vc = 0;
    end
    if (rc == REF_HALF) begin
        ref_out <= ~ref_out;
        rc = 0;
    end
end
endmodule // osc_model
`default_nettype wire

// >>> dv/synth_core_monitor.sv
/* Port checker for synth_core.
   Assumes one clock and the asynchronous active-low reset of the core. */
`timescale 1ns/100ps
`default_nettype none
module synth_mon (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ext_ctrl_sel_in,
    input wire logic prescale_pulse_out,
    input wire logic mod_ctrl_out,
    input wire logic div_pulse_out,
    input wire logic fb_out,
    input wire logic ref_div_out,
    input wire logic pump_up_n_out,
    input wire logic pump_down_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!rst_n_in);
sequence cycle_end;
    div_pulse_out;
endsequence
sequence ref_fell;
    !ref_div_out && ($past(ref_div_out, 2) || $past(ref_div_out, 3));
endsequence
////////////////////////////////////////////////////////////////////////////////
pulse_once_a: assert property (prescale_pulse_out |=> !prescale_pulse_out)
    else $error("prescaler pulse longer than one cycle");
end_on_wrap_a: assert property (cycle_end |-> prescale_pulse_out && !fb_out)
    else $error("cycle end not on a prescaler wrap");
fb_fall_a: assert property ($fell(fb_out) |-> cycle_end)
    else $error("feedback fell outside cycle end");
fb_rise_a: assert property ($rose(fb_out)
    |-> prescale_pulse_out || $past(prescale_pulse_out))
    else $error("feedback rose without a wrap");
pump_excl_a: assert property (!(pump_down_out && !pump_up_n_out))
    else $error("both pumps active");
up_release_a: assert property ($rose(pump_up_n_out) |-> !fb_out && $past(fb_out, 2))
    else $error("pump-up released without feedback fall");
down_release_a: assert property ($fell(pump_down_out) |-> ref_fell)
    else $error("pump-down released without reference fall");
ref_toggle_a: assert property ($changed(ref_div_out)
    |-> $past(ref_div_out, 2) != ref_div_out)
    else $error("reference divider toggled too soon");
mod_fall_a: assert property ($fell(mod_ctrl_out) && !ext_ctrl_sel_in
    && !$past(ext_ctrl_sel_in) |-> prescale_pulse_out)
    else $error("modulus changed off a wrap");
endmodule // synth_mon
bind synth_core synth_mon u_mon (.clk_in, .rst_n_in, .ext_ctrl_sel_in, .prescale_pulse_out,
    .mod_ctrl_out, .div_pulse_out, .fb_out, .ref_div_out, .pump_up_n_out, .pump_down_out);
`default_nettype wire

// >>> dv/tb.sv
/* Self-checking bench for synth_core.
   Assumes osc_model supplies the VCO and reference levels. */
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("mismatch %s expected %0d seen %0d", nm, ex, got); end end
module tb;
logic clk_in = 1'b0;
logic rst_n_in = 1'b0;
logic three_mod_in = 1'b0;
logic ext_ctrl_sel_in = 1'b1;
logic mod_ctrl_in = 1'b1;
logic [9:0] swallow_count_in = 10'h001;
logic [9:0] mid_count_in = 10'h000;
logic [9:0] main_count_in = 10'h001;
logic vco_run = 1'b0;
logic ref_run = 1'b0;
logic vco_q = 1'b0;
logic ref_q = 1'b0;
wire logic vco_in, ref_osc_in, prescale_pulse_out, mod_ctrl_out, div_pulse_out;
wire logic fb_out, ref_div_out, pump_up_n_out, pump_down_out;
int error_cnt = 0;
int n_tests = 0;
int vco_cnt = 0;
int ref_cnt = 0;
always #5 clk_in = ~clk_in;
// Rising edges counted where the core samples them
always @(posedge clk_in) begin
    if (vco_in && !vco_q) vco_cnt++;
    if (ref_osc_in && !ref_q) ref_cnt++;
    vco_q = vco_in;
    ref_q = ref_osc_in;
end
osc_model u_osc (.clk_in, .vco_run_in(vco_run), .ref_run_in(ref_run), .vco_out(vco_in),
    .ref_out(ref_osc_in));
synth_core u_dut (.clk_in, .rst_n_in, .vco_in, .ref_osc_in, .three_mod_in, .ext_ctrl_sel_in,
    .mod_ctrl_in, .swallow_count_in, .mid_count_in, .main_count_in, .prescale_pulse_out,
    .mod_ctrl_out, .div_pulse_out, .fb_out, .ref_div_out, .pump_up_n_out, .pump_down_out);
////////////////////////////////////////////////////////////////////////////////
task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
task automatic fail(input string nm);
    error_cnt++;
    $display("mismatch %s expected event seen timeout", nm);
    stop_test;
endtask
task automatic prog(input logic three, input int a, input int b, input int m);
    @(negedge clk_in);
    ext_ctrl_sel_in = 1'b0;
    three_mod_in = three;
    swallow_count_in = 10'(a);
    mid_count_in = 10'(b);
    main_count_in = 10'(m);
endtask
// Counts source edges between two consecutive events of the chosen output
task automatic measure(input int sel, input int ex, input string nm);
    int k;
    int c0;
    logic rq;
    for (int p = 0; p < 2; p++) begin
        rq = ref_div_out;
        for (k = 0; k < 3000; k++) begin
            @(negedge clk_in);
            if (sel == 0 ? prescale_pulse_out === 1'b1 :
                sel == 1 ? div_pulse_out === 1'b1 : ref_div_out !== rq) break;
        end
        if (k == 3000) fail(nm);
        if (p == 0) c0 = sel == 2 ? ref_cnt : vco_cnt;
    end
    `CHECK(nm, ex, (sel == 2 ? ref_cnt : vco_cnt) - c0)
endtask
task automatic wait_pump(input logic dn, input logic v);
    int k;
    for (k = 0; k < 300; k++) begin
        @(negedge clk_in);
        if ((dn ? pump_down_out : pump_up_n_out) === v) break;
    end
    if (k == 300) fail("pump state");
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    logic [6:0] rv;
    @(negedge clk_in);
    rv = {prescale_pulse_out, mod_ctrl_out, div_pulse_out, fb_out, ref_div_out, pump_up_n_out,
        pump_down_out};
    `CHECK("reset outputs", 7'h2E, rv)
endtask
task automatic t_prescale;
    for (int m = 1; m >= 0; m--) begin
        @(negedge clk_in);
        mod_ctrl_in = m[0];
        vco_run = 1'b1;
        measure(0, 15 + m, "prescale period");
    end
endtask
task automatic t_two;
    // Second case puts the swallow count at its largest legal value
    for (int a = 2; a <= 3; a++) begin
        prog(1'b0, a, 0, 3);
        measure(1, 45 + a, "two-modulus ratio");
        `CHECK("modulus control", 1'b1, mod_ctrl_out)
        `CHECK("feedback level", 1'b0, fb_out)
    end
endtask
task automatic t_three;
    prog(1'b1, 1, 2, 3);
    measure(1, 312, "three-modulus ratio");
    prog(1'b1, 0, 0, 2);
    measure(1, 200, "three-modulus no swallow");
    `CHECK("modulus control", 1'b0, mod_ctrl_out)
endtask
task automatic t_short;
    prog(1'b0, 1, 0, 1);
    measure(1, 16, "shortest cycle");
endtask
task automatic t_ref;
    @(negedge clk_in);
    vco_run = 1'b0;
    ref_run = 1'b1;
    measure(2, 2, "reference divide");
endtask
task automatic t_pfd;
    wait_pump(1'b0, 1'b0);
    repeat (40) @(negedge clk_in);
    `CHECK("pump-up held", 1'b0, pump_up_n_out)
    `CHECK("pump-down idle", 1'b0, pump_down_out)
    // A main count of one keeps the feedback low, so two is the least that gives it edges
    prog(1'b0, 1, 0, 2);
    ref_run = 1'b0;
    vco_run = 1'b1;
    wait_pump(1'b1, 1'b1);
    `CHECK("pump-up idle", 1'b1, pump_up_n_out)
    `CHECK("pump-down active", 1'b1, pump_down_out)
endtask
initial begin
    repeat (3) @(posedge clk_in);
    t_reset;
    @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    t_prescale;
    t_two;
    t_three;
    t_short;
    t_ref;
    t_pfd;
    stop_test;
end
endmodule // tb
`default_nettype wire
